// ===== host_model.sv
`timescale 1ns/10ps
module host_model (
   input  wire logic        go,
   input  wire logic        serial_in,
   output logic             link_clk,
   output logic             chain_bit,
   output logic             active,
   output logic [12:0]      captured
);
   initial begin
      link_clk  = 1'b0;
      chain_bit = 1'b0;
      active    = 1'b0;
      captured  = 13'h0000;
      forever begin
         @(posedge go);
         active = 1'b1;
         // Odd offset keeps the link out of step with clk
         #3;
         // Two rises sync the start, second fall loads, then 12 bits and one chained bit
         for (int i = 1; i <= 15; i++) begin
            #6 link_clk = 1'b1;
            if (i >= 3) captured = {captured[11:0], serial_in};
            // Chain bit moves after the rise so it is settled at the fall
            chain_bit = i[0];
            #6 link_clk = 1'b0;
         end
         // Clock stands still between frames
         active = 1'b0;
      end
   end
endmodule // host_model

// ===== link_shifter.sv
`timescale 1ns/10ps
`include "sar_adc_regs.svh"
module link_shifter (
   input  wire logic shift_clk,
   input  wire logic reset_n,
   result_if.dst     res,
   input  wire logic chain_in,
   output logic      serial_bit
);
   logic                 tgl_s;
   logic                 tgl_seen_reg;
   sar_adc_pkg::result_t sr_reg;

   // Data moves on the falling edge so it is stable at the rising edge
   sync2 #(.WIDTH(1), .RESET_VAL(1'b0)) u_tgl_sync (
      .clk     (shift_clk),
      .reset_n (reset_n),
      .d       (res.tx_toggle),
      .q       (tgl_s)
   );

   always_ff @(negedge shift_clk or negedge reset_n) begin
      if (!reset_n) begin
         tgl_seen_reg <= 1'b0;
      end else begin
         tgl_seen_reg <= tgl_s;
      end
   end

   // Word is held still for the whole frame, so it crosses quasi-static
   always_ff @(negedge shift_clk or negedge reset_n) begin
      if (!reset_n) begin
         sr_reg <= '0;
      end else if (tgl_s != tgl_seen_reg) begin
         sr_reg <= res.tx_word;
      end else begin
         sr_reg <= {sr_reg[`RES_MSB-1:0], chain_in};
      end
   end

   assign serial_bit = sr_reg[`RES_MSB];
endmodule // link_shifter

// ===== result_if.sv
`timescale 1ns/10ps
interface result_if;
   sar_adc_pkg::result_t tx_word;
   logic                 tx_toggle;
   modport src (output tx_word, output tx_toggle);
   modport dst (input tx_word, input tx_toggle);
endinterface

// ===== sar_adc_output_interface.sv
`timescale 1ns/10ps
`include "sar_adc_regs.svh"
module sar_adc_output_interface #(
   parameter int CONV_CYCLES = `CONV_TIME_NS / `CLK_PERIOD_NS,
   parameter int SCLK_HALF   = `SCLK_HALF_CYCLES
) (
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  wire logic                 cs_n,
   input  wire logic                 convert_read_strobe,
   input  wire logic                 output_half_sel,
   input  wire logic                 output_format_sel,
   input  wire logic                 shift_clock_source_sel,
   input  wire logic                 analog_sleep,
   input  wire logic                 reference_shutdown,
   input  wire sar_adc_pkg::result_t sar_code,
   input  wire logic                 shift_clock_pin_in,
   output logic                      shift_clock_pin_out,
   output logic                      shift_clock_pin_oe,
   input  wire logic                 daisy_chain_in,
   output logic                      serial_result_out,
   output logic [`BYTE_W-1:0]        parallel_data_out,
   output logic                      parallel_data_oe,
   output logic                      busy_n,
   output logic                      analog_enable,
   output logic                      internal_ref_enable
);
   localparam int CNT_W = $clog2(CONV_CYCLES + 1);

   logic [`PIN_SYNC_W-1:0] pins_raw;
   logic [`PIN_SYNC_W-1:0] pins_s;
   logic                   cs_s;
   logic                   rc_s;
   logic                   half_s;
   logic                   fmt_s;
   logic                   ext_s;
   logic                   sleep_s;
   logic                   reference_shutdown_s;

   logic                   comb_s;
   logic                   comb_prev_reg;
   logic                   start;

   sar_adc_pkg::conv_state_e state_reg;
   logic [CNT_W-1:0]         conv_cnt_reg;
   logic                     conv_done;
   sar_adc_pkg::result_t     result_reg;
   sar_adc_pkg::result_t     formatted;
   sar_adc_pkg::result_t     tx_word_reg;
   logic                     tx_toggle_reg;

   logic                     int_sending_reg;
   logic                     sclk_reg;
   logic [`DIV_W-1:0]        div_cnt_reg;
   logic [`BIT_CNT_W-1:0]    bit_cnt_reg;
   sar_adc_pkg::result_t     int_sr_reg;
   logic                     half_tick;
   logic                     link_bit;
   logic                     serial_sel_reg;

   result_if res_bus ();

   assign pins_raw = {reference_shutdown, analog_sleep, shift_clock_source_sel,
                      output_format_sel, output_half_sel, convert_read_strobe, cs_n};

   sync2 #(.WIDTH(`PIN_SYNC_W), .RESET_VAL(`PIN_SYNC_RESET)) u_pin_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .d       (pins_raw),
      .q       (pins_s)
   );

   assign cs_s    = pins_s[0];
   assign rc_s    = pins_s[1];
   assign half_s  = pins_s[2];
   assign fmt_s   = pins_s[3];
   assign ext_s   = pins_s[4];
   assign sleep_s = pins_s[5];
   assign reference_shutdown_s  = pins_s[6];

   // Convert request is low on the OR of select and strobe
   assign comb_s = cs_s | rc_s;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         comb_prev_reg <= 1'b1;
      end else begin
         comb_prev_reg <= comb_s;
      end
   end

   // Only an idle converter takes a falling request edge
   assign start = comb_prev_reg & ~comb_s & (state_reg == sar_adc_pkg::ST_IDLE);

   assign conv_done = (conv_cnt_reg == CNT_W'(CONV_CYCLES - 1));

   // Straight binary is the two's complement code with its MSB flipped
   assign formatted = fmt_s ? {~sar_code[`RES_MSB], sar_code[`RES_MSB-1:0]}
                            : sar_code;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= sar_adc_pkg::ST_IDLE;
      end else begin
         unique case (state_reg)
            sar_adc_pkg::ST_IDLE: begin
               if (start) begin
                  state_reg <= sar_adc_pkg::ST_CONVERT;
               end
            end
            sar_adc_pkg::ST_CONVERT: begin
               if (conv_done) begin
                  state_reg <= sar_adc_pkg::ST_FINISH;
               end
            end
            sar_adc_pkg::ST_FINISH: begin
               state_reg <= sar_adc_pkg::ST_WAIT_TX;
            end
            sar_adc_pkg::ST_WAIT_TX: begin
               // Busy also covers the internal serial frame
               if (!int_sending_reg) begin
                  state_reg <= sar_adc_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         conv_cnt_reg <= '0;
      end else if (state_reg == sar_adc_pkg::ST_CONVERT) begin
         conv_cnt_reg <= conv_cnt_reg + CNT_W'(1);
      end else begin
         conv_cnt_reg <= '0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         result_reg <= '0;
      end else if (state_reg == sar_adc_pkg::ST_CONVERT && conv_done) begin
         result_reg <= formatted;
      end
   end

   // Busy rises only once the parallel register carries the new word
   assign busy_n = (state_reg == sar_adc_pkg::ST_IDLE);

   // Previous result is frozen at start for either serial path
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_word_reg   <= '0;
         tx_toggle_reg <= 1'b0;
      end else if (start) begin
         tx_word_reg   <= result_reg;
         tx_toggle_reg <= ~tx_toggle_reg;
      end
   end

   assign res_bus.tx_word   = tx_word_reg;
   assign res_bus.tx_toggle = tx_toggle_reg;

   // Level enable: a read needs no strobe edge, only select low and strobe high
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         parallel_data_oe <= 1'b0;
      end else begin
         parallel_data_oe <= ~cs_s & rc_s;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         parallel_data_out <= '0;
      end else if (half_s) begin
         parallel_data_out <= {result_reg[`LOWER_MSB:0], `LOW_FILL};
      end else begin
         parallel_data_out <= result_reg[`RES_MSB:`UPPER_LSB];
      end
   end

   assign half_tick = (div_cnt_reg == `DIV_W'(SCLK_HALF - 1));

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt_reg <= '0;
      end else if (!int_sending_reg || half_tick) begin
         div_cnt_reg <= '0;
      end else begin
         div_cnt_reg <= div_cnt_reg + `DIV_W'(1);
      end
   end

   // Internal frame: clock idles low, data changes on its falling edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         int_sending_reg <= 1'b0;
         sclk_reg        <= 1'b0;
         bit_cnt_reg     <= '0;
         int_sr_reg      <= '0;
      end else if (start && !ext_s) begin
         int_sending_reg <= 1'b1;
         sclk_reg        <= 1'b0;
         bit_cnt_reg     <= '0;
         int_sr_reg      <= result_reg;
      end else if (int_sending_reg && half_tick) begin
         sclk_reg <= ~sclk_reg;
         if (sclk_reg) begin
            int_sr_reg  <= {int_sr_reg[`RES_MSB-1:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg + `BIT_CNT_W'(1);
            if (bit_cnt_reg == `BIT_CNT_W'(`SER_BITS - 1)) begin
               int_sending_reg <= 1'b0;
            end
         end
      end
   end

   link_shifter u_link (
      .shift_clk  (shift_clock_pin_in),
      .reset_n    (reset_n),
      .res        (res_bus),
      .chain_in   (daisy_chain_in),
      .serial_bit (link_bit)
   );

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         serial_sel_reg <= 1'b0;
      end else begin
         serial_sel_reg <= ext_s;
      end
   end

   // Select is static in use; the link bit is already a flop output
   assign serial_result_out   = serial_sel_reg ? link_bit : int_sr_reg[`RES_MSB];
   assign shift_clock_pin_out = sclk_reg;
   assign shift_clock_pin_oe  = ~serial_sel_reg;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         analog_enable       <= 1'b0;
         internal_ref_enable <= 1'b0;
      end else begin
         analog_enable       <= ~sleep_s;
         internal_ref_enable <= ~reference_shutdown_s;
      end
   end

   // Helper: rising internal clock edges per frame
   logic [`BIT_CNT_W:0] pulse_cnt_reg;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pulse_cnt_reg <= '0;
      end else if (start && !ext_s) begin
         pulse_cnt_reg <= '0;
      end else if (int_sending_reg && half_tick && !sclk_reg) begin
         pulse_cnt_reg <= pulse_cnt_reg + (`BIT_CNT_W+1)'(1);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_start_drops_busy: assert property (start |=> (!busy_n) [*8])
      else $error("busy did not stay low after a start");

   a_busy_ignores_req: assert property (!busy_n && $fell(comb_s) |=> $stable(tx_word_reg))
      else $error("request taken while busy");

   a_req_starts_conv: assert property ($fell(comb_s) && busy_n |=> !busy_n)
      else $error("idle request edge did not start a conversion");

   a_oe_off_gate: assert property ((cs_s || !rc_s) |=> !parallel_data_oe)
      else $error("parallel pins enabled while deselected or converting");

   a_oe_on_read: assert property ((!cs_s && rc_s) |=> parallel_data_oe)
      else $error("parallel pins not enabled for a read");

   a_upper_half: assert property (!half_s |=>
      parallel_data_out == $past(result_reg[`RES_MSB:`UPPER_LSB]))
      else $error("upper half not on parallel pins");

   a_lower_half: assert property (half_s |=>
      parallel_data_out == {$past(result_reg[`LOWER_MSB:0]), `LOW_FILL})
      else $error("lower half or low fill wrong");

   a_format_code: assert property (state_reg == sar_adc_pkg::ST_CONVERT && conv_done |=>
      result_reg[`RES_MSB] == ($past(sar_code[`RES_MSB]) ^ $past(fmt_s)))
      else $error("result MSB does not match the output format");

   a_busy_new_data: assert property ($rose(busy_n) |->
      $past(state_reg) == sar_adc_pkg::ST_WAIT_TX && !$past(int_sending_reg))
      else $error("busy rose before the result settled");

   // A request still low when busy rises must not restart
   a_no_restart_held: assert property ($rose(busy_n) && !comb_s && !comb_prev_reg |=>
      busy_n)
      else $error("held request restarted a conversion");

   a_top_pin_bit: assert property (1'b1 |=> parallel_data_out[`BYTE_W-1] ==
      $past(half_s ? result_reg[`LOWER_MSB] : result_reg[`RES_MSB]))
      else $error("top parallel pin carries the wrong bit");

   a_low_fill: assert property (half_s |=> parallel_data_out[`UPPER_LSB-1:0] == `LOW_FILL)
      else $error("lower pins not driven low for the low half");

   a_int_frame_start: assert property (start && !ext_s |=>
      int_sending_reg && serial_result_out == $past(result_reg[`RES_MSB]))
      else $error("internal serial frame did not start with the MSB");

   a_twelve_pulses: assert property ($fell(int_sending_reg) |->
      pulse_cnt_reg == (`BIT_CNT_W+1)'(`SER_BITS))
      else $error("internal frame pulse count wrong");

   a_int_clk_idle: assert property (!int_sending_reg |-> !shift_clock_pin_out)
      else $error("internal shift clock moved outside a frame");

   a_clock_dir: assert property (ext_s |=> !shift_clock_pin_oe)
      else $error("shift clock pin driven in external mode");

   a_clock_drive: assert property (!ext_s |=> shift_clock_pin_oe)
      else $error("shift clock pin not driven in internal mode");

   a_sleep_analog: assert property (sleep_s |=> !analog_enable)
      else $error("analog not shut down by sleep");

   a_wake_analog: assert property (!sleep_s |=> analog_enable)
      else $error("analog not powered while awake");

   a_ref_shutdown: assert property (reference_shutdown_s |=> !internal_ref_enable)
      else $error("internal reference still on after shutdown");

   a_ref_enable: assert property (!reference_shutdown_s |=> internal_ref_enable)
      else $error("internal reference off without shutdown");

   c_int_conversion: cover property (start && !ext_s ##1 int_sending_reg);
   c_ext_conversion: cover property (start && ext_s);
   c_low_half_read: cover property (parallel_data_oe && half_s);
   c_cs_fall_start: cover property ($fell(cs_s) && !rc_s && busy_n);
   c_req_while_busy: cover property (!busy_n && $fell(comb_s));
endmodule // sar_adc_output_interface

// ===== sar_adc_pkg.sv
package sar_adc_pkg;
   typedef logic [11:0] result_t;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CONVERT,
      ST_FINISH,
      ST_WAIT_TX
   } conv_state_e;
endpackage

// ===== sar_adc_regs.svh
// Operation
// - Half select picks upper eight or lower four
// - Top pin: bit 11 low, bit 3 high
// - Half high: upper pins carry bits 3..0
// - Lower pins: bits 7..4, else driven low
// - Data pins off when deselected or converting
// - Shift clock pin direction follows source select
// - Serial bits follow the shift clock
// - External clock: accept daisy-chain serial input
// - Strobe fall, selected, idle starts conversion
// - Strobe high while selected enables outputs
// - Select ORed with strobe; select fall starts
// - Internal clock: start also sends previous result
// - Busy low until outputs hold new result
// - Sleep stops analog, digital keeps running
// - Reference shutdown disables internal reference
// - Format select: straight binary or two's complement
// - Requests while busy are ignored
// - Serial result: twelve pulses, MSB first
`ifndef SAR_ADC_REGS_SVH
`define SAR_ADC_REGS_SVH

`define RES_W            12
`define RES_MSB          11
`define SER_BITS         12
`define BIT_CNT_W        4
`define BYTE_W           8
`define UPPER_LSB        4
`define LOWER_MSB        3
`define LOW_FILL         4'h0
`define CLK_PERIOD_NS    10
`define CONV_TIME_NS     15000
`define SCLK_HALF_CYCLES 5
`define DIV_W            8
`define PIN_SYNC_W       7
// Select and strobe idle high so reset cannot fake a start
`define PIN_SYNC_RESET   7'h03

`endif

// ===== sync2.sv
`timescale 1ns/10ps
module sync2 #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_reg <= RESET_VAL;
         q        <= RESET_VAL;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule // sync2

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
   localparam int CONV = 20;
   typedef struct packed {
      logic [11:0] code;
      logic        fmt;
      logic [7:0]  hi;
      logic [7:0]  lo;
   } row_s;
   row_s rows [5] = '{'{12'hABC, 1'b0, 8'hAB, 8'hC0}, '{12'hABC, 1'b1, 8'h2B, 8'hC0},
                      '{12'h800, 1'b1, 8'h00, 8'h00}, '{12'h7FF, 1'b0, 8'h7F, 8'hF0},
                      '{12'h001, 1'b1, 8'h80, 8'h10}};
   logic                 clk, reset_n, cs_n, strobe, output_half_sel, output_format_sel;
   logic                 shift_clock_source_sel, analog_sleep, reference_shutdown, go;
   sar_adc_pkg::result_t sar_code;
   logic                 shift_clock_pin_out, shift_clock_pin_oe, serial_result_out;
   logic [7:0]           parallel_data_out;
   logic                 parallel_data_oe, busy_n, analog_enable, internal_ref_enable;
   logic                 host_clk, chain_bit, host_active;
   logic [12:0]          host_cap;
   logic [11:0]          int_cap = 12'h000;
   int                   int_cnt = 0;
   int                   miscompares, num_checks, w;
   wire                  shift_pin = shift_clock_pin_oe ? shift_clock_pin_out : host_clk;

   sar_adc_output_interface #(.CONV_CYCLES(CONV), .SCLK_HALF(2)) u_sar_adc_output_interface (
      .clk(clk), .reset_n(reset_n), .cs_n(cs_n), .convert_read_strobe(strobe),
      .output_half_sel(output_half_sel), .output_format_sel(output_format_sel),
      .shift_clock_source_sel(shift_clock_source_sel), .analog_sleep(analog_sleep),
      .reference_shutdown(reference_shutdown), .sar_code(sar_code),
      .shift_clock_pin_in(shift_pin), .shift_clock_pin_out(shift_clock_pin_out),
      .shift_clock_pin_oe(shift_clock_pin_oe), .daisy_chain_in(chain_bit),
      .serial_result_out(serial_result_out), .parallel_data_out(parallel_data_out),
      .parallel_data_oe(parallel_data_oe), .busy_n(busy_n), .analog_enable(analog_enable),
      .internal_ref_enable(internal_ref_enable));

   host_model u_host_model (.go(go), .serial_in(serial_result_out), .link_clk(host_clk),
      .chain_bit(chain_bit), .active(host_active), .captured(host_cap));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge shift_clock_pin_out) begin
      int_cap <= {int_cap[10:0], serial_result_out};
      int_cnt <= int_cnt + 1;
   end

   task automatic check(input logic [12:0] got, input logic [12:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic complete_run();
      if (miscompares == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Start by strobe fall or by select fall, wait out busy, leave strobe high to read
   task automatic conv(input logic [11:0] code, input logic ext, input logic by_cs,
                       input logic poke);
      int n;
      n = 0;
      @(negedge clk);
      sar_code = code;
      if (by_cs) begin
         cs_n = 1'b1;
         strobe = 1'b0;
         @(negedge clk);
         cs_n = 1'b0;
      end else
         strobe = 1'b0;
      while (busy_n !== 1'b0 && n < 10) begin
         @(negedge clk);
         n++;
      end
      check(13'(busy_n), 13'h0000);
      if (ext) begin
         go = 1'b1;
         @(negedge clk);
         go = 1'b0;
      end
      check(13'(parallel_data_oe), 13'h0000);
      n = 0;
      while (busy_n !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
         if (poke && n == 4) cs_n = 1'b1;
         if (poke && n == 6) cs_n = 1'b0;
      end
      check(13'(n >= CONV - 2), 13'h0001);
      check(13'(n < 300), 13'h0001);
      if (ext) check(13'(n <= CONV + 4), 13'h0001);
      // Request still low at busy rise must not restart
      repeat (5) begin
         @(negedge clk);
         check(13'(busy_n), 13'h0001);
      end
      strobe = 1'b1;
   endtask

   initial begin
      #100000;
      miscompares++;
      complete_run();
   end

   initial begin
      {reset_n, go, output_half_sel, output_format_sel, shift_clock_source_sel} = 5'h00;
      {analog_sleep, reference_shutdown, miscompares, num_checks} = '0;
      {cs_n, strobe} = 2'h3;
      sar_code = 12'h000;
      repeat (6) @(negedge clk);
      reset_n = 1'b1;
      repeat (3) @(negedge clk);
      check(13'(busy_n), 13'h0001);
      check(13'(parallel_data_oe), 13'h0000);
      check(13'(shift_clock_pin_oe), 13'h0001);
      // Ends with both high: conversions below run with analog asleep
      for (int k = 0; k < 4; k++) begin
         analog_sleep = k[0];
         reference_shutdown = k[1];
         repeat (4) @(negedge clk);
         check(13'(analog_enable), 13'(!k[0]));
         check(13'(internal_ref_enable), 13'(!k[1]));
      end
      cs_n = 1'b0;
      foreach (rows[i]) begin
         @(negedge clk);
         output_format_sel = rows[i].fmt;
         conv(rows[i].code, 1'b0, 1'b0, 1'b0);
         for (int h = 0; h < 2; h++) begin
            @(negedge clk);
            output_half_sel = h[0];
            repeat (4) @(negedge clk);
            check(13'(parallel_data_oe), 13'h0001);
            check(13'(parallel_data_out), 13'(h ? rows[i].lo : rows[i].hi));
         end
      end
      @(negedge clk);
      cs_n = 1'b1;
      repeat (4) @(negedge clk);
      check(13'(parallel_data_oe), 13'h0000);
      cs_n = 1'b0;
      output_format_sel = 1'b0;
      conv(12'h5A3, 1'b0, 1'b1, 1'b0);
      w = int_cnt;
      conv(12'h5A3, 1'b0, 1'b1, 1'b0);
      check(13'(int_cnt - w), 13'h000C);
      check({1'b0, int_cap}, 13'h05A3);
      @(negedge clk);
      shift_clock_source_sel = 1'b1;
      repeat (4) @(negedge clk);
      check(13'(shift_clock_pin_oe), 13'h0000);
      conv(12'h3C6, 1'b1, 1'b0, 1'b1);
      conv(12'h3C6, 1'b1, 1'b0, 1'b0);
      w = 0;
      while (host_active && w < 50) begin
         @(negedge clk);
         w++;
      end
      check(host_cap, 13'h078D);
      check(13'(host_active), 13'h0000);
      // Mid-run reset with a read pending: idle outputs, then the read reopens
      @(negedge clk);
      reset_n = 1'b0;
      repeat (2) @(negedge clk);
      check(13'(busy_n), 13'h0001);
      check(13'(parallel_data_oe), 13'h0000);
      check(13'(parallel_data_out), 13'h0000);
      check(13'(shift_clock_pin_oe), 13'h0001);
      reset_n = 1'b1;
      repeat (4) @(negedge clk);
      check(13'(parallel_data_oe), 13'h0001);
      check(13'(shift_clock_pin_oe), 13'h0000);
      complete_run();
   end
endmodule // tb_top
